// >>> hw/ivg_pkg.sv
// Package with register map, field positions and vector codes of the interrupt vector generator
package ivg_pkg;
	localparam logic [3:0] IVG_MODE_ADDR = 4'h0;
	localparam logic [3:0] IVG_ACKDEC_ADDR = 4'h4;
	localparam logic [3:0] IVG_STATUS_ADDR = 4'h8;
	localparam logic [15:0] IVG_MODE_RESET = 16'h0000;
	localparam logic [15:0] IVG_MODE_WMASK = 16'hf7e0;
	localparam logic [2:0] IVG_ACKDEC_RESET = 3'h0;
	localparam int IVG_PIN_MODE_BIT = 15;
	localparam int IVG_L7_VSRC_BIT = 14;
	localparam int IVG_L6_VSRC_BIT = 13;
	localparam int IVG_L1_VSRC_BIT = 12;
	localparam int IVG_L7_TRIG_BIT = 10;
	localparam int IVG_L6_TRIG_BIT = 9;
	localparam int IVG_L1_TRIG_BIT = 8;
	localparam int IVG_VB_HI = 7;
	localparam int IVG_VB_LO = 5;
	localparam int IVG_ACKDEC_L7 = 2;
	localparam int IVG_ACKDEC_L6 = 1;
	localparam int IVG_ACKDEC_L1 = 0;
	localparam logic [7:0] IVG_UNINIT_VECTOR = 8'h0f;
	localparam logic [4:0] IVG_CODE_L7 = 5'h17;
	localparam logic [4:0] IVG_CODE_L6 = 5'h16;
	localparam logic [4:0] IVG_CODE_L1 = 5'h11;
	localparam logic [4:0] IVG_CODE_ERROR = 5'h00;
	localparam logic [2:0] IVG_LEVEL_INTERNAL = 3'h4;
	localparam logic [2:0] IVG_LEVEL_NONE = 3'h0;
	localparam logic [2:0] IVG_ENC_NONE = 3'h7;
	localparam logic [2:0] IVG_ENC_UNAVAIL = 3'h3;
	localparam logic [1:0] IVG_RESP_OKAY = 2'h0;
	localparam logic [1:0] IVG_RESP_SLVERR = 2'h2;
endpackage

// >>> hw/ivg_vector_gen.sv
// Interrupt vector generation and global mode register with an AXI4-Lite slave
// Function
// - Pending external and unmasked internal requests reach the core by priority level.
// - Internal acknowledge returns vector of highest pending unmasked internal source.
// - Internal vectoring selectable for external levels 1, 6, 7 in both pin modes.
// - Transfer acknowledge is driven whenever this block supplies the vector.
// - Fifteen internal sources (bits 15 to 1) have fixed priority inside level 4.
// - Per-level acknowledge decode outputs for 7, 6, 1 when enabled, else pins free.
// - Autovector overrides bus vector; never asserted in level 4 acknowledge.
// - Internal vector is base field in top three bits plus five-bit source code.
// - External levels 7, 6, 1 use codes 10111, 10110, 10001; others none.
// - Internal sources use descending codes 01111 down to 00001 by priority.
// - Level 4 acknowledge with nothing pending returns error code 00000.
// - Global mode register clears to zero only on total system reset.
// - Vector 0F is returned until the vector base field has been written.
// - Bit 15 selects encoded priority inputs or dedicated level 7/6/1 requests.
// - Bit 14 clear: level 7 vector supplied here; set: not supplied.
// - Bit 13 clear: level 6 vector supplied here; set: left to external device.
// - Bit 12 clear: level 1 vector supplied here; set: not supplied.
// - Dedicated trigger bits: clear means low level pends, set means falling edge.
`timescale 1ns/1ps
`default_nettype none
module ivg_vector_gen
	import ivg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] encoded_priority_inputs_n,
	input wire logic level7_request_in_n,
	input wire logic level6_request_in_n,
	input wire logic level1_request_in_n,
	input wire logic [15:1] internal_request_pending,
	input wire logic [15:1] internal_request_enable,
	output logic [2:0] core_request_level,
	input wire logic iack_active,
	input wire logic [2:0] iack_level,
	output logic [7:0] vector_data,
	output logic vector_data_oe,
	output logic transfer_acknowledge_out,
	output logic transfer_acknowledge_oe,
	output logic level7_ack_decode_n,
	output logic level6_ack_decode_n,
	output logic level1_ack_decode_n,
	output logic [2:0] ack_decode_oe,
	output logic internal_ack_pulse,
	output logic [3:0] internal_ack_source
);

	logic [15:0] global_interrupt_mode_reg;
	logic [2:0] ack_decode_enable_reg;
	logic vector_base_written_reg;
	logic [2:0] enc_meta_reg;
	logic [2:0] enc_sync_reg;
	logic [2:0] ded_meta_reg;
	logic [2:0] ded_sync_reg;
	logic [2:0] ded_prev_reg;
	logic [2:0] edge_pend_reg;
	logic [2:0] ded_pend;
	logic [2:0] ext_level;
	logic [2:0] present_level;
	logic [15:1] int_active;
	logic [4:0] int_code;
	logic int_any;
	logic iack_prev_reg;
	logic iack_start;
	logic supply;
	logic [4:0] low_code;
	logic [7:0] vector_next;
	logic [2:0] ackdec_reg;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] rdata_next;
	logic rd_hit;
	logic wr_hit_mode;
	logic wr_hit_ackdec;
	logic mode_dedicated;

	assign mode_dedicated = global_interrupt_mode_reg[IVG_PIN_MODE_BIT];

	// Pins are asynchronous to aclk; only the second stage feeds logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enc_meta_reg <= IVG_ENC_NONE;
			enc_sync_reg <= IVG_ENC_NONE;
			ded_meta_reg <= 3'h7;
			ded_sync_reg <= 3'h7;
		end else begin
			enc_meta_reg <= encoded_priority_inputs_n;
			enc_sync_reg <= enc_meta_reg;
			ded_meta_reg <= {level7_request_in_n, level6_request_in_n, level1_request_in_n};
			ded_sync_reg <= ded_meta_reg;
		end
	end

	// Edge capture for dedicated requests; cleared when that level is acknowledged
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ded_prev_reg <= 3'h7;
			edge_pend_reg <= 3'h0;
		end else begin
			ded_prev_reg <= ded_sync_reg;
			for (int i = 0; i < 3; i++) begin
				if (ded_prev_reg[i] && !ded_sync_reg[i])
					edge_pend_reg[i] <= 1'b1;
				else if (iack_start && iack_level == (i == 2 ? 3'h7 : (i == 1 ? 3'h6 : 3'h1)))
					edge_pend_reg[i] <= 1'b0;
			end
		end
	end

	always_comb begin
		// Level trigger follows the synced pin; edge trigger holds until that level is acknowledged
		ded_pend[2] = global_interrupt_mode_reg[IVG_L7_TRIG_BIT] ? edge_pend_reg[2] : !ded_sync_reg[2];
		ded_pend[1] = global_interrupt_mode_reg[IVG_L6_TRIG_BIT] ? edge_pend_reg[1] : !ded_sync_reg[1];
		ded_pend[0] = global_interrupt_mode_reg[IVG_L1_TRIG_BIT] ? edge_pend_reg[0] : !ded_sync_reg[0];
	end

	// Encoded inputs: 000 is level 7 down to 110 as level 1; level 4 is not offered to pins
	always_comb begin
		ext_level = IVG_LEVEL_NONE;
		if (mode_dedicated) begin
			if (ded_pend[2])
				ext_level = 3'h7;
			else if (ded_pend[1])
				ext_level = 3'h6;
			else if (ded_pend[0])
				ext_level = 3'h1;
		end else if (enc_sync_reg != IVG_ENC_NONE && enc_sync_reg != IVG_ENC_UNAVAIL) begin
			ext_level = 3'h7 - enc_sync_reg;
		end
	end

	// Source bit index equals its five-bit code, so the highest set bit gives the code
	assign int_active = internal_request_pending & internal_request_enable;
	always_comb begin
		int_code = IVG_CODE_ERROR;
		for (int i = 1; i <= 15; i++) begin
			if (int_active[i])
				int_code = 5'(i);
		end
	end
	assign int_any = |int_active;

	always_comb begin
		present_level = ext_level;
		if (int_any && ext_level < IVG_LEVEL_INTERNAL)
			present_level = IVG_LEVEL_INTERNAL;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			core_request_level <= IVG_LEVEL_NONE;
		else
			core_request_level <= present_level;
	end

	assign iack_start = iack_active && !iack_prev_reg;

	always_comb begin
		supply = 1'b0;
		low_code = IVG_CODE_ERROR;
		// Levels 5, 3 and 2 never get a vector here; the peripheral or the autovector answers
		unique case (iack_level)
			3'h7: begin
				supply = !global_interrupt_mode_reg[IVG_L7_VSRC_BIT];
				low_code = IVG_CODE_L7;
			end
			3'h6: begin
				supply = !global_interrupt_mode_reg[IVG_L6_VSRC_BIT];
				low_code = IVG_CODE_L6;
			end
			3'h4: begin
				supply = 1'b1;
				low_code = int_code;
			end
			3'h1: begin
				supply = !global_interrupt_mode_reg[IVG_L1_VSRC_BIT];
				low_code = IVG_CODE_L1;
			end
			default: begin
				supply = 1'b0;
				low_code = IVG_CODE_ERROR;
			end
		endcase
	end

	always_comb begin
		// Base bits are not trusted until byte 0 of the mode register has been written once
		if (vector_base_written_reg)
			vector_next = {global_interrupt_mode_reg[IVG_VB_HI:IVG_VB_LO], low_code};
		else
			vector_next = IVG_UNINIT_VECTOR;
	end

	// Vector is frozen at the start of the cycle so a late pending change cannot tear it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			iack_prev_reg <= 1'b0;
			vector_data <= 8'h00;
			vector_data_oe <= 1'b0;
			transfer_acknowledge_out <= 1'b0;
			transfer_acknowledge_oe <= 1'b0;
		end else begin
			iack_prev_reg <= iack_active;
			if (!iack_active) begin
				vector_data <= 8'h00;
				vector_data_oe <= 1'b0;
				transfer_acknowledge_out <= 1'b0;
				transfer_acknowledge_oe <= 1'b0;
			end else if (iack_start && supply) begin
				vector_data <= vector_next;
				vector_data_oe <= 1'b1;
				transfer_acknowledge_out <= 1'b1;
				transfer_acknowledge_oe <= 1'b1;
			end
		end
	end

	// Pulse lets pending and in-service logic elsewhere clear or set the taken source
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			internal_ack_pulse <= 1'b0;
			internal_ack_source <= 4'h0;
		end else begin
			internal_ack_pulse <= iack_start && iack_level == IVG_LEVEL_INTERNAL && int_any;
			if (iack_start && iack_level == IVG_LEVEL_INTERNAL)
				internal_ack_source <= int_code[3:0];
		end
	end

	// Autovector is the core's business; no level 4 filter is needed here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ackdec_reg <= 3'h0;
		end else begin
			ackdec_reg[2] <= iack_active && iack_level == 3'h7;
			ackdec_reg[1] <= iack_active && iack_level == 3'h6;
			ackdec_reg[0] <= iack_active && iack_level == 3'h1;
		end
	end

	assign level7_ack_decode_n = !(ackdec_reg[2] && ack_decode_enable_reg[IVG_ACKDEC_L7]);
	assign level6_ack_decode_n = !(ackdec_reg[1] && ack_decode_enable_reg[IVG_ACKDEC_L6]);
	assign level1_ack_decode_n = !(ackdec_reg[0] && ack_decode_enable_reg[IVG_ACKDEC_L1]);
	assign ack_decode_oe = ack_decode_enable_reg;

	// Write address and data are taken together; one write in flight at a time
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready = s_axi_awready;
	assign wr_fire = s_axi_awready;
	assign wr_hit_mode = s_axi_awaddr == IVG_MODE_ADDR;
	assign wr_hit_ackdec = s_axi_awaddr == IVG_ACKDEC_ADDR;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_interrupt_mode_reg <= IVG_MODE_RESET;
			vector_base_written_reg <= 1'b0;
		end else if (wr_fire && wr_hit_mode) begin
			// A write to byte lane 1 alone leaves the base field unwritten
			if (s_axi_wstrb[0]) begin
				global_interrupt_mode_reg[7:0] <= s_axi_wdata[7:0] & IVG_MODE_WMASK[7:0];
				vector_base_written_reg <= 1'b1;
			end
			if (s_axi_wstrb[1])
				global_interrupt_mode_reg[15:8] <= s_axi_wdata[15:8] & IVG_MODE_WMASK[15:8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ack_decode_enable_reg <= IVG_ACKDEC_RESET;
		else if (wr_fire && wr_hit_ackdec && s_axi_wstrb[0])
			ack_decode_enable_reg <= s_axi_wdata[2:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= IVG_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_hit_mode || wr_hit_ackdec) ? IVG_RESP_OKAY : IVG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// One read in flight: a new address is refused while read data waits
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_comb begin
		rdata_next = 32'h0000_0000;
		rd_hit = 1'b1;
		// Unmapped reads return zero data with a slave error
		unique case (s_axi_araddr)
			IVG_MODE_ADDR: rdata_next = {16'h0000, global_interrupt_mode_reg};
			IVG_ACKDEC_ADDR: rdata_next = {29'h0000_0000, ack_decode_enable_reg};
			IVG_STATUS_ADDR: rdata_next = {20'h0_0000, vector_base_written_reg, edge_pend_reg,
				1'b0, ext_level, 1'b0, core_request_level};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= IVG_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rd_hit ? IVG_RESP_OKAY : IVG_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> dv/ivg_vector_gen_assertions.sv
// Port checker for the interrupt vector generator
`timescale 1ns/1ps
`default_nettype none
module ivg_vector_gen_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:1] internal_request_pending,
	input wire logic [15:1] internal_request_enable,
	input wire logic [2:0] core_request_level,
	input wire logic iack_active,
	input wire logic [2:0] iack_level,
	input wire logic [7:0] vector_data,
	input wire logic vector_data_oe,
	input wire logic transfer_acknowledge_out,
	input wire logic transfer_acknowledge_oe,
	input wire logic level7_ack_decode_n,
	input wire logic level6_ack_decode_n,
	input wire logic level1_ack_decode_n,
	input wire logic [2:0] ack_decode_oe,
	input wire logic internal_ack_pulse,
	input wire logic [3:0] internal_ack_source
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_vector_with_ack: assert property (vector_data_oe |-> transfer_acknowledge_oe && transfer_acknowledge_out)
		else $error("vector without acknowledge");
	chk_release_after_end: assert property ($fell(iack_active) |=> !vector_data_oe && !transfer_acknowledge_oe)
		else $error("vector not released");
	chk_vector_held: assert property (vector_data_oe && iack_active |=> vector_data_oe && $stable(vector_data))
		else $error("vector changed in cycle");
	chk_no_vector_levels: assert property ($rose(iack_active) && iack_level inside {3'h5, 3'h3, 3'h2}
		|=> !vector_data_oe [*2])
		else $error("vector on unvectored level");
	chk_level4_code: assert property ($rose(iack_active) && iack_level == 3'h4 |=> vector_data_oe
		&& (vector_data == 8'h0f || vector_data[4:0] == {1'b0, internal_ack_source}))
		else $error("bad level 4 vector");
	chk_internal_taken: assert property ($rose(iack_active) && iack_level == 3'h4
		&& |(internal_request_pending & internal_request_enable) |=> internal_ack_pulse ##1 !internal_ack_pulse)
		else $error("internal source not taken");
	chk_decode_level7: assert property ($rose(iack_active) && iack_level == 3'h7
		|=> level7_ack_decode_n == !ack_decode_oe[2])
		else $error("level 7 decode wrong");
	chk_decode_level6: assert property ($rose(iack_active) && iack_level == 3'h6
		|=> level6_ack_decode_n == !ack_decode_oe[1])
		else $error("level 6 decode wrong");
	chk_decode_level1: assert property ($rose(iack_active) && iack_level == 3'h1
		|=> level1_ack_decode_n == !ack_decode_oe[0])
		else $error("level 1 decode wrong");
	chk_internal_level: assert property ((|(internal_request_pending & internal_request_enable)) [*2]
		|-> core_request_level >= 3'h4)
		else $error("internal request not presented");
endmodule
bind ivg_vector_gen ivg_vector_gen_chk u_chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.internal_request_pending(internal_request_pending),
	.internal_request_enable(internal_request_enable),
	.core_request_level(core_request_level),
	.iack_active(iack_active),
	.iack_level(iack_level),
	.vector_data(vector_data),
	.vector_data_oe(vector_data_oe),
	.transfer_acknowledge_out(transfer_acknowledge_out),
	.transfer_acknowledge_oe(transfer_acknowledge_oe),
	.level7_ack_decode_n(level7_ack_decode_n),
	.level6_ack_decode_n(level6_ack_decode_n),
	.level1_ack_decode_n(level1_ack_decode_n),
	.ack_decode_oe(ack_decode_oe),
	.internal_ack_pulse(internal_ack_pulse),
	.internal_ack_source(internal_ack_source)
);
`default_nettype wire

// >>> dv/ivg_core_model.sv
// Behavioural core running interrupt acknowledge cycles
`timescale 1ns/1ps
`default_nettype none
module ivg_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic go,
	input wire logic [2:0] go_level,
	input wire logic [3:0] hold,
	output logic iack_active,
	output logic [2:0] iack_level
);
	logic [2:0] level_reg;
	logic [3:0] count_reg;
	// Junk level outside a cycle, so a stale level is never trusted
	assign iack_level = iack_active ? level_reg : ~level_reg;
	// Never autovectors and never drives the acknowledge itself
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			iack_active <= 1'b0;
			level_reg <= 3'h0;
			count_reg <= 4'h0;
		end else if (go && !iack_active) begin
			iack_active <= 1'b1;
			level_reg <= go_level;
			count_reg <= hold;
		end else if (iack_active) begin
			if (count_reg == 4'h0) iack_active <= 1'b0;
			count_reg <= count_reg - 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_interrupt_vector_generation.sv
// Self-checking bench for the interrupt vector generator
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_vector_generation;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf, internal_ack_source;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, iack_level, ack_decode_oe, core_request_level;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] encoded_priority_inputs_n = 3'h7, go_level = '0, vb;
	logic level7_request_in_n = 1'b1, level6_request_in_n = 1'b1, level1_request_in_n = 1'b1;
	logic [15:1] internal_request_pending = '0, internal_request_enable = '0, m;
	logic iack_active, vector_data_oe, transfer_acknowledge_out, transfer_acknowledge_oe, internal_ack_pulse;
	logic level7_ack_decode_n, level6_ack_decode_n, level1_ack_decode_n, go = 1'b0, voe_d = 1'b0;
	logic [7:0] vector_data;
	logic [3:0] hold = '0;
	logic [15:0] rnd = 16'h8dc5;
	logic [33:0] rq[$], bq[$], vq[$];
	logic [2:0] lv[6] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h2, 3'h1};
	logic [4:0] cd[6] = '{5'h17, 5'h16, 5'h00, 5'h00, 5'h00, 5'h11};
	int mismatches = 0, compares = 0;
	always #12.5 aclk = ~aclk;
	ivg_vector_gen dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .encoded_priority_inputs_n(encoded_priority_inputs_n),
		.level7_request_in_n(level7_request_in_n), .level6_request_in_n(level6_request_in_n),
		.level1_request_in_n(level1_request_in_n), .internal_request_pending(internal_request_pending),
		.internal_request_enable(internal_request_enable), .core_request_level(core_request_level),
		.iack_active(iack_active), .iack_level(iack_level), .vector_data(vector_data),
		.vector_data_oe(vector_data_oe), .transfer_acknowledge_out(transfer_acknowledge_out),
		.transfer_acknowledge_oe(transfer_acknowledge_oe), .level7_ack_decode_n(level7_ack_decode_n),
		.level6_ack_decode_n(level6_ack_decode_n), .level1_ack_decode_n(level1_ack_decode_n),
		.ack_decode_oe(ack_decode_oe), .internal_ack_pulse(internal_ack_pulse),
		.internal_ack_source(internal_ack_source)
	);
	ivg_core_model core (
		.aclk(aclk), .aresetn(aresetn), .go(go), .go_level(go_level), .hold(hold),
		.iack_active(iack_active), .iack_level(iack_level)
	);
	function logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function logic [4:0] hi(input logic [15:1] v);
		hi = 5'h00;
		for (int i = 1; i < 16; i++) if (v[i]) hi = i[4:0];
	endfunction
	task complete_run;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait: a hung handshake ends the run instead of the simulator
	task automatic await(ref logic s, input logic v);
		int n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (s !== v && n < 200);
		if (s !== v) begin
			mismatches++;
			complete_run();
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		bq.push_back(34'(r));
		await(s_axi_awready, 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		await(s_axi_bvalid, 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [3:0] a, input logic [33:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rq.push_back(e);
		await(s_axi_arready, 1'b1);
		s_axi_arvalid <= 1'b0;
		await(s_axi_rvalid, 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task ack(input logic [2:0] l);
		rnd = nx(rnd);
		go_level <= l;
		hold <= rnd[3:0];
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		await(iack_active, 1'b0);
		repeat (2) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		voe_d <= vector_data_oe;
		if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), bq.pop_front());
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (vector_data_oe && !voe_d) chk({transfer_acknowledge_out, vector_data}, vq.size() > 0 ? vq.pop_front() : 'x);
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(4'h0, 34'h0);
		rd(4'hc, {2'h2, 32'h0});
		internal_request_pending <= 15'h0001;
		internal_request_enable <= 15'h0001;
		vq.push_back(34'h10f);
		ack(3'h4);
		wr(4'h0, 32'hffffffff, 2'h0);
		rd(4'h0, 34'hf7e0);
		internal_request_enable <= '0;
		level7_request_in_n <= 1'b0;
		// Edge trigger needs one more edge than the level path before the level is presented
		repeat (5) @(posedge aclk);
		chk(34'(core_request_level), 34'h7);
		level7_request_in_n <= 1'b1;
		for (int i = 0; i < 6; i++) ack(lv[i]);
		chk(34'(core_request_level), 34'h0);
		rnd = nx(rnd);
		vb = rnd[2:0];
		wr(4'h4, 32'h7, 2'h0);
		wr(4'h0, {24'h0, vb, 5'h00}, 2'h0);
		encoded_priority_inputs_n <= 3'h1;
		repeat (4) @(posedge aclk);
		chk(34'(core_request_level), 34'h6);
		encoded_priority_inputs_n <= 3'h7;
		for (int i = 0; i < 6; i++) begin
			if (cd[i] != 5'h00) vq.push_back(34'({1'b1, vb, cd[i]}));
			ack(lv[i]);
		end
		for (int k = 0; k < 10; k++) begin
			rnd = nx(rnd);
			m = (k == 9) ? 15'h0 : {rnd[7:0], rnd[15:9]};
			internal_request_pending <= rnd[15:1];
			internal_request_enable <= m;
			vq.push_back(34'({1'b1, vb, hi(rnd[15:1] & m)}));
			ack(3'h4);
		end
		wr(4'h0, {16'h0, 4'h7, 4'h0, vb, 5'h00}, 2'h0);
		for (int i = 0; i < 6; i++) ack(lv[i]);
		wr(4'h0, {16'h0, 4'h8, 4'h0, vb, 5'h00}, 2'h0);
		level1_request_in_n <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(34'(core_request_level), 34'h1);
		vq.push_back(34'({1'b1, vb, 5'h11}));
		ack(3'h1);
		level1_request_in_n <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(34'(core_request_level), 34'h0);
		wr(4'hc, 32'h1, 2'h2);
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(4'h0, 34'h0);
		vq.push_back(34'h10f);
		ack(3'h4);
		repeat (4) @(posedge aclk);
		chk(34'(vq.size() + rq.size() + bq.size()), 34'h0);
		complete_run();
	end
endmodule
`default_nettype wire
